// file: verilog/dmm_params.svh
// Constants shared by both ends of the analog control link
`ifndef DMM_PARAMS_SVH
`define DMM_PARAMS_SVH
`define REG_BITS 8
`define NUM_REGS 5
`define CHAIN_BITS 40
`define FAST_CHAIN_BITS 16
`define PHASE_LSB 0
`define PHASE_MSB 2
`define GAIN_BIT 3
`define FAST_BIT 4
`define SIG_LSB 5
`define SIG_MSB 6
`define COM_BIT 7
`define RANGE_LSB 0
`define RANGE_MSB 2
`define FUNC_LSB 3
`define FUNC_MSB 5
`define FOUR_WIRE_BIT 6
`define PH_REF 3'h1
`define PH_SIG 3'h2
`define PH_ZERO 3'h3
`define PH_OHMS_REF_HI 3'h4
`define PH_OHMS_REF_LO 3'h5
`define PH_OHMS_SENSE_HI 3'h6
`define PH_OHMS_SENSE_LO 3'h7
`define FUNC_RTD 3'h5
`define FUNC_TC 3'h6
`define RANGE_LOWEST 3'h0
`define RANGE_SECOND 3'h1
`define SW_REF 0
`define SW_SIG_MAIN 1
`define SW_SIG_ALT1 2
`define SW_SIG_ALT2 3
`define SW_COM0 4
`define SW_COM1 5
`define SW_OHMS_REF_HI 6
`define SW_SENSE_LO 7
`define SW_PRECHARGE 8
`define SW_FRONT_REAR 9
`define NUM_SW 10
`define RTD_UP_COUNT 24'h0F_0000
`define RTD_DOWN_COUNT 24'h01_8000
`define SYS_CLK_KHZ 100000
`define FAST_CLK_KHZ 3840
`define FAST_HALF_CYCLES (`SYS_CLK_KHZ / (2 * `FAST_CLK_KHZ))
`define PRECHARGE_NS 2000
`define PRECHARGE_CYCLES ((`PRECHARGE_NS * `SYS_CLK_KHZ) / 1000000)
`define SHIFT_HALF_NS 60
`define SHIFT_HALF_CYCLES ((`SHIFT_HALF_NS * `SYS_CLK_KHZ) / 1000000)
`define STROBE_NS 100
`define STROBE_CYCLES ((`STROBE_NS * `SYS_CLK_KHZ) / 1000000)
`define SETTLE_US 100
`define SETTLE_CYCLES ((`SETTLE_US * `SYS_CLK_KHZ) / 1000)
`define BALANCE_US 1000
`define BALANCE_CYCLES ((`BALANCE_US * `SYS_CLK_KHZ) / 1000)
`define LINK_MARGIN_CYCLES 12
`endif

// file: verilog/dmm_pkg.sv
// Types shared by both ends of the analog control link
package dmm_pkg;
  typedef enum logic [1:0] {CONV_IDLE, CONV_BALANCE, CONV_FINAL} conv_state_type;
  typedef enum logic [2:0] {H_IDLE, H_SHIFT, H_STROBE, H_SETTLE, H_BALANCE, H_FINAL} host_state_type;
endpackage : dmm_pkg

// file: verilog/dmm_link_if.sv
// Isolated link between the processor end and the analog control end
interface dmm_link_if;
  logic shift_clk;
  logic shift_data;
  logic strobe;
  logic input_enable;
  logic cb_toggle;
  logic fs_gate;
  logic fs_comp;
  modport processor (output shift_clk, shift_data, strobe, input_enable, input cb_toggle, fs_gate, fs_comp);
  modport analog (input shift_clk, shift_data, strobe, input_enable, output cb_toggle, fs_gate, fs_comp);
endinterface : dmm_link_if

// file: verilog/dmm_analog_end.sv
// Analog end: shift-store chain, multiplexer phases and converter sequencing
// Notes on behaviour
// - Reference phase selects the reference switch
// - Signal phase turns on exactly one signal switch
// - Zero phase selects one common switch
// - Ohms reference high uses only its switch
// - Ohms ref low and sense high use main
// - Ohms sense low uses the sense-low switch
// - Precharge path briefly precedes the main switch
// - Front/rear detector never joins any phase
// - Each phase integration delivers its count result
// - Gain bit selects unity or ten feedback
// - Charge balance starts only on input enable
// - Processor waits settling delay before enabling input
// - All charge-balance pulses are counted
// - Final slope turns charge-balance feedback off
// - Final slope counts comparator gated fast clock
// - Counting stops when the comparator falls
// - All controls come from the shift-store chain, except range and four-wire under RTD and thermocouple
// - Bits shift serially with separate clock line
// - Strobe moves all registers to outputs together; in fast mode it moves only the main and option registers
// - Fast mode skips the three middle registers
// - RTD uses four-wire, autoranges lowest two ranges
// - Thermocouple fixes the lowest voltage range
`include "dmm_params.svh"
module dmm_analog_end #(
  parameter int COUNT_BITS = 24
) (
  input  wire logic                      clock,
  input  wire logic                      arst_n,
  dmm_link_if.analog                     link,
  input  wire logic                      duty_cycle_comparator,
  input  wire logic                      final_slope_comparator,
  output logic [`NUM_SW-1:0]             mux_switch,
  output logic                           gain_x10,
  output logic                           charge_balance_feedback_switch,
  output logic                           final_slope_feedback_switch,
  output logic [`RANGE_MSB-`RANGE_LSB:0] range_select,
  output logic                           four_wire,
  output logic [2*`REG_BITS-1:0]         relay_controls,
  output logic [`REG_BITS-1:0]           option_controls,
  output dmm_pkg::conv_state_type        conv_state,
  output logic                           phase_done,
  output logic [COUNT_BITS-1:0]          cb_count,
  output logic [COUNT_BITS-1:0]          fs_count
);
  import dmm_pkg::*;
  localparam int OPT_LSB = `CHAIN_BITS - `REG_BITS;
  localparam int RB = `REG_BITS;

  // Every link pin and comparator crosses isolation, so all pass two flops
  logic [5:0] sync_meta;
  logic [5:0] sync_q;
  logic [5:0] sync_d;
  logic       sclk_rise;
  logic       sdata;
  logic       strobe_rise;
  logic       ie;
  logic       ie_rise;
  logic       dc_rise;
  logic       fs;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_meta <= '0;
      sync_q    <= '0;
      sync_d    <= '0;
    end else begin
      sync_meta <= {final_slope_comparator, duty_cycle_comparator, link.input_enable,
                    link.strobe, link.shift_data, link.shift_clk};
      sync_q    <= sync_meta;
      sync_d    <= sync_q;
    end
  end

  assign sclk_rise   = sync_q[0] & ~sync_d[0];
  assign sdata       = sync_q[1];
  assign strobe_rise = sync_q[2] & ~sync_d[2];
  assign ie          = sync_q[3];
  assign ie_rise     = sync_q[3] & ~sync_d[3];
  assign dc_rise     = sync_q[4] & ~sync_d[4];
  assign fs          = sync_q[5];

  // Shift-store chain: main register low, option register high
  logic [`CHAIN_BITS-1:0] chain;
  logic [`CHAIN_BITS-1:0] next_chain;
  logic [`CHAIN_BITS-1:0] held;
  logic [`CHAIN_BITS-1:0] next_held;
  logic                   fast_mode;

  assign fast_mode = held[`FAST_BIT];

  always_comb begin
    next_chain = chain;
    next_held  = held;
    if (sclk_rise) begin
      if (fast_mode) begin
        next_chain[RB-1:0]                = {chain[RB-2:0], sdata};
        next_chain[`CHAIN_BITS-1:OPT_LSB] = {chain[`CHAIN_BITS-2:OPT_LSB], chain[RB-1]};
      end else begin
        next_chain = {chain[`CHAIN_BITS-2:0], sdata};
      end
    end
    // Outputs move only on the strobe, never while bits are shifting
    if (strobe_rise) begin
      if (fast_mode) begin
        next_held[RB-1:0]                = chain[RB-1:0];
        next_held[`CHAIN_BITS-1:OPT_LSB] = chain[`CHAIN_BITS-1:OPT_LSB];
      end else begin
        next_held = chain;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      chain <= '0;
      held  <= '0;
    end else begin
      chain <= next_chain;
      held  <= next_held;
    end
  end

  // Decode of the held main and function registers
  logic [2:0] phase;
  logic [1:0] sig_sel;
  logic [2:0] func;
  logic       uses_main;
  logic [7:0] pre_count;
  logic [7:0] next_pre_count;

  assign phase     = held[`PHASE_MSB:`PHASE_LSB];
  assign sig_sel   = held[`SIG_MSB:`SIG_LSB];
  assign func      = held[RB+`FUNC_MSB:RB+`FUNC_LSB];
  assign uses_main = (phase == `PH_SIG && sig_sel == 2'h0) || phase == `PH_OHMS_REF_LO
                     || phase == `PH_OHMS_SENSE_HI;

  // Restarted on every strobe so each main-switch phase gets its own precharge
  always_comb begin
    if (strobe_rise) begin
      next_pre_count = 8'(`PRECHARGE_CYCLES);
    end else if (pre_count != 8'h00) begin
      next_pre_count = pre_count - 8'h01;
    end else begin
      next_pre_count = pre_count;
    end
  end

  logic [`NUM_SW-1:0]             next_sw;
  logic [`RANGE_MSB-`RANGE_LSB:0] next_range;
  logic                           next_four_wire;
  logic [`RANGE_MSB-`RANGE_LSB:0] rtd_range;
  logic [`RANGE_MSB-`RANGE_LSB:0] next_rtd_range;

  always_comb begin
    next_sw = '0;
    case (phase)
      `PH_REF: begin
        next_sw[`SW_REF] = 1'b1;
      end
      `PH_SIG: begin
        case (sig_sel)
          2'h0:    next_sw[`SW_SIG_MAIN] = 1'b1;
          2'h1:    next_sw[`SW_SIG_ALT1] = 1'b1;
          default: next_sw[`SW_SIG_ALT2] = 1'b1;
        endcase
      end
      `PH_ZERO: begin
        next_sw[held[`COM_BIT] ? `SW_COM1 : `SW_COM0] = 1'b1;
      end
      `PH_OHMS_REF_HI: begin
        next_sw[`SW_OHMS_REF_HI] = 1'b1;
      end
      `PH_OHMS_REF_LO, `PH_OHMS_SENSE_HI: begin
        next_sw[`SW_SIG_MAIN] = 1'b1;
      end
      `PH_OHMS_SENSE_LO: begin
        next_sw[`SW_SENSE_LO] = 1'b1;
      end
      default: next_sw = '0;
    endcase
    if (uses_main && pre_count != 8'h00) begin
      next_sw[`SW_SIG_MAIN]  = 1'b0;
      next_sw[`SW_PRECHARGE] = 1'b1;
    end
    next_sw[`SW_FRONT_REAR] = 1'b0;
    if (func == `FUNC_TC) begin
      next_range     = `RANGE_LOWEST;
      next_four_wire = 1'b0;
    end else if (func == `FUNC_RTD) begin
      next_range     = rtd_range;
      next_four_wire = 1'b1;
    end else begin
      next_range     = held[RB+`RANGE_MSB:RB+`RANGE_LSB];
      next_four_wire = held[RB+`FOUR_WIRE_BIT];
    end
  end

  // Converter sequencing and fast count clock
  conv_state_type          next_conv_state;
  logic [4:0]              div;
  logic [4:0]              next_div;
  logic                    fast_clk;
  logic                    next_fast_clk;
  logic                    cb_tog;
  logic                    next_cb_tog;
  logic [COUNT_BITS-1:0]   next_cb_count;
  logic [COUNT_BITS-1:0]   next_fs_count;
  logic                    next_done;
  logic                    fs_gate;
  logic                    fs_comp;

  always_comb begin
    next_div        = (div == 5'(`FAST_HALF_CYCLES - 1)) ? 5'h00 : div + 5'h01;
    next_fast_clk   = (div == 5'(`FAST_HALF_CYCLES - 1)) ? ~fast_clk : fast_clk;
    next_conv_state = conv_state;
    next_cb_count   = cb_count;
    next_fs_count   = fs_count;
    next_cb_tog     = cb_tog;
    next_done       = 1'b0;
    next_rtd_range  = rtd_range;
    case (conv_state)
      CONV_IDLE: begin
        if (ie_rise) begin
          next_conv_state = CONV_BALANCE;
          next_cb_count   = '0;
          next_fs_count   = '0;
        end
      end
      CONV_BALANCE: begin
        if (dc_rise) begin
          next_cb_count = cb_count + 1'b1;
          next_cb_tog   = ~cb_tog;
        end
        if (!ie) begin
          next_conv_state = CONV_FINAL;
        end
      end
      CONV_FINAL: begin
        if (fs && next_fast_clk && !fs_gate) begin
          next_fs_count = fs_count + 1'b1;
        end
        if (!fs) begin
          next_conv_state = CONV_IDLE;
          next_done       = 1'b1;
          // Autorange decided from the sense-high count of an RTD cycle
          if (func == `FUNC_RTD && phase == `PH_OHMS_SENSE_HI) begin
            if (cb_count > COUNT_BITS'(`RTD_UP_COUNT)) begin
              next_rtd_range = `RANGE_SECOND;
            end else if (cb_count < COUNT_BITS'(`RTD_DOWN_COUNT)) begin
              next_rtd_range = `RANGE_LOWEST;
            end
          end
        end
      end
      default: next_conv_state = CONV_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pre_count                      <= '0;
      mux_switch                     <= '0;
      gain_x10                       <= 1'b0;
      range_select                   <= '0;
      four_wire                      <= 1'b0;
      relay_controls                 <= '0;
      option_controls                <= '0;
      rtd_range                      <= `RANGE_LOWEST;
      conv_state                     <= CONV_IDLE;
      div                            <= '0;
      fast_clk                       <= 1'b0;
      cb_tog                         <= 1'b0;
      cb_count                       <= '0;
      fs_count                       <= '0;
      phase_done                     <= 1'b0;
      charge_balance_feedback_switch <= 1'b0;
      final_slope_feedback_switch    <= 1'b0;
      fs_gate                        <= 1'b0;
      fs_comp                        <= 1'b0;
    end else begin
      pre_count                      <= next_pre_count;
      mux_switch                     <= next_sw;
      gain_x10                       <= held[`GAIN_BIT];
      range_select                   <= next_range;
      four_wire                      <= next_four_wire;
      relay_controls                 <= held[3*RB-1+RB:2*RB];
      option_controls                <= held[`CHAIN_BITS-1:OPT_LSB];
      rtd_range                      <= next_rtd_range;
      conv_state                     <= next_conv_state;
      div                            <= next_div;
      fast_clk                       <= next_fast_clk;
      cb_tog                         <= next_cb_tog;
      cb_count                       <= next_cb_count;
      fs_count                       <= next_fs_count;
      phase_done                     <= next_done;
      charge_balance_feedback_switch <= (next_conv_state == CONV_BALANCE);
      final_slope_feedback_switch    <= (next_conv_state == CONV_FINAL);
      // Gate stays low on the entry cycle so every rise the far end sees is one local count
      fs_gate                        <= (conv_state == CONV_FINAL) && fs && next_fast_clk;
      fs_comp                        <= (next_conv_state == CONV_FINAL) && fs;
    end
  end

  assign link.cb_toggle = cb_tog;
  assign link.fs_gate   = fs_gate;
  assign link.fs_comp   = fs_comp;
endmodule : dmm_analog_end

// file: verilog/dmm_processor_end.sv
// Processor end: loads the control chain and runs one phase integration
`include "dmm_params.svh"
module dmm_processor_end #(
  parameter int COUNT_BITS     = 24,
  parameter int SETTLE_CYCLES  = `SETTLE_CYCLES,
  parameter int BALANCE_CYCLES = `BALANCE_CYCLES
) (
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  dmm_link_if.processor               link,
  input  wire logic                   start,
  input  wire logic [`CHAIN_BITS-1:0] control_word,
  input  wire logic                   fast_select,
  output logic                        busy,
  output dmm_pkg::host_state_type     host_state,
  output logic                        result_valid,
  output logic [COUNT_BITS-1:0]       cb_count,
  output logic [COUNT_BITS-1:0]       fs_count
);
  import dmm_pkg::*;
  localparam int OPT_LSB = `CHAIN_BITS - `REG_BITS;

  logic [2:0] sync_meta;
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       tog_seen;
  logic       gate_rise;
  logic       comp;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_meta <= '0;
      sync_q    <= '0;
      sync_d    <= '0;
    end else begin
      sync_meta <= {link.fs_comp, link.fs_gate, link.cb_toggle};
      sync_q    <= sync_meta;
      sync_d    <= sync_q;
    end
  end

  assign tog_seen  = sync_q[0] ^ sync_d[0];
  assign gate_rise = sync_q[1] & ~sync_d[1];
  assign comp      = sync_q[2];

  host_state_type         next_state;
  logic [`CHAIN_BITS-1:0] shreg;
  logic [`CHAIN_BITS-1:0] next_shreg;
  logic [5:0]             bits;
  logic [5:0]             next_bits;
  logic                   fast;
  logic                   next_fast;
  logic [31:0]            tm;
  logic [31:0]            next_tm;
  logic                   sclk;
  logic                   next_sclk;
  logic                   sdata;
  logic                   strobe;
  logic                   ie;
  logic                   next_valid;
  logic [COUNT_BITS-1:0]  next_cb_count;
  logic [COUNT_BITS-1:0]  next_fs_count;
  logic [5:0]             last_bit;

  assign last_bit = fast ? 6'(`FAST_CHAIN_BITS - 1) : 6'(`CHAIN_BITS - 1);

  always_comb begin
    next_state    = host_state;
    next_shreg    = shreg;
    next_bits     = bits;
    next_fast     = fast;
    next_tm       = tm + 32'h0000_0001;
    next_sclk     = sclk;
    next_valid    = 1'b0;
    next_cb_count = cb_count;
    next_fs_count = fs_count;
    // Stragglers from the far end still arrive after the enable drops
    if ((host_state == H_BALANCE || host_state == H_FINAL) && tog_seen) begin
      next_cb_count = cb_count + 1'b1;
    end
    case (host_state)
      H_IDLE: begin
        next_tm = '0;
        if (start) begin
          next_fast  = fast_select;
          next_bits  = '0;
          next_state = H_SHIFT;
          next_shreg = fast_select ? {control_word[`CHAIN_BITS-1:OPT_LSB], control_word[`REG_BITS-1:0],
                                      {(`CHAIN_BITS - `FAST_CHAIN_BITS){1'b0}}} : control_word;
        end
      end
      H_SHIFT: begin
        // Data changes only on the falling edge so it is stable at the rise
        if (tm == 32'(`SHIFT_HALF_CYCLES - 1)) begin
          next_tm   = '0;
          next_sclk = ~sclk;
          if (sclk) begin
            next_shreg = {shreg[`CHAIN_BITS-2:0], 1'b0};
            next_bits  = bits + 6'h01;
            if (bits == last_bit) begin
              next_state = H_STROBE;
            end
          end
        end
      end
      H_STROBE: begin
        if (tm == 32'(`STROBE_CYCLES - 1)) begin
          next_tm    = '0;
          next_state = H_SETTLE;
        end
      end
      H_SETTLE: begin
        if (tm == 32'(SETTLE_CYCLES - 1)) begin
          next_tm       = '0;
          next_state    = H_BALANCE;
          next_cb_count = '0;
          next_fs_count = '0;
        end
      end
      H_BALANCE: begin
        if (tm == 32'(BALANCE_CYCLES - 1)) begin
          next_tm    = '0;
          next_state = H_FINAL;
        end
      end
      H_FINAL: begin
        if (gate_rise && comp) begin
          next_fs_count = fs_count + 1'b1;
        end
        if (tm >= 32'(`LINK_MARGIN_CYCLES)) begin
          next_tm = tm;
          if (!comp) begin
            next_state = H_IDLE;
            next_valid = 1'b1;
          end
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      host_state   <= H_IDLE;
      shreg        <= '0;
      bits         <= '0;
      fast         <= 1'b0;
      tm           <= '0;
      sclk         <= 1'b0;
      sdata        <= 1'b0;
      strobe       <= 1'b0;
      ie           <= 1'b0;
      busy         <= 1'b0;
      result_valid <= 1'b0;
      cb_count     <= '0;
      fs_count     <= '0;
    end else begin
      host_state   <= next_state;
      shreg        <= next_shreg;
      bits         <= next_bits;
      fast         <= next_fast;
      tm           <= next_tm;
      sclk         <= next_sclk;
      sdata        <= next_shreg[`CHAIN_BITS-1];
      strobe       <= (next_state == H_STROBE);
      ie           <= (next_state == H_BALANCE);
      busy         <= (next_state != H_IDLE);
      result_valid <= next_valid;
      cb_count     <= next_cb_count;
      fs_count     <= next_fs_count;
    end
  end

  assign link.shift_clk    = sclk;
  assign link.shift_data   = sdata;
  assign link.strobe       = strobe;
  assign link.input_enable = ie;
endmodule : dmm_processor_end

// file: sim/dmm_link_checker.sv
// Assertions on the isolated link between the two ends
module dmm_link_checker #(
  parameter int SETTLE_CYCLES  = 20,
  parameter int BALANCE_CYCLES = 200
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic shift_clk,
  input wire logic shift_data,
  input wire logic strobe,
  input wire logic input_enable,
  input wire logic cb_toggle,
  input wire logic fs_gate,
  input wire logic fs_comp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] high_run;
  logic [19:0] low_run;
  logic [7:0]  rises;
  // Only low_run saturates so a stuck line cannot wrap into a false pass; high_run and rises wrap
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      high_run <= '0;
      low_run  <= '0;
      rises    <= '0;
    end else begin
      high_run <= input_enable ? high_run + 20'h0_0001 : '0;
      low_run  <= strobe ? '0 : (low_run == 20'hF_FFFF ? low_run : low_run + 20'h0_0001);
      rises    <= strobe ? '0 : rises + {7'h00, $rose(shift_clk)};
    end
  end
  default clocking main_cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_strobe_len; $rose(strobe) |-> strobe[*8] ##1 strobe[*2] ##1 !strobe; endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe width wrong");
  property p_quiet_strobe; strobe |-> !shift_clk && !input_enable; endproperty
  a_quiet_strobe: assert property (p_quiet_strobe) else $error("activity during strobe");
  property p_half; $rose(shift_clk) |-> shift_clk[*6] ##1 !shift_clk; endproperty
  a_half: assert property (p_half) else $error("shift clock half wrong");
  property p_data; shift_clk && $past(shift_clk) |-> $stable(shift_data); endproperty
  a_data: assert property (p_data) else $error("data moved while clock high");
  property p_bits; $rose(strobe) |-> rises == 8'd40 || rises == 8'd16; endproperty
  a_bits: assert property (p_bits) else $error("chain bit count wrong");
  property p_settle; $rose(input_enable) |-> low_run >= SETTLE_CYCLES; endproperty
  a_settle: assert property (p_settle) else $error("enable before settling");
  property p_balance; $fell(input_enable) |-> high_run == BALANCE_CYCLES; endproperty
  a_balance: assert property (p_balance) else $error("balance length wrong");
  property p_gate; $rose(fs_gate) |-> fs_comp; endproperty
  a_gate: assert property (p_gate) else $error("gate without comparator");
  property p_final; input_enable |-> !fs_comp; endproperty
  a_final: assert property (p_final) else $error("final slope during balance");
  c_balance: cover property ($fell(input_enable));
  c_gate: cover property ($rose(fs_gate));
  c_fast: cover property ($rose(strobe) && rises == 8'd16);
  c_toggle: cover property ($changed(cb_toggle));
endmodule : dmm_link_checker

// file: sim/testbench.sv
// Bench joining both ends of the analog control link
`include "dmm_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, arst_n, start, fast_select;
  logic        duty_cmp = 1'b0;
  logic        fs_cmp;
  logic [39:0] control_word;
  logic [9:0]  mux_switch;
  logic        gain_x10, four_wire, busy, result_valid, phase_done;
  logic        cb_fb, fs_fb;
  logic [2:0]  range_select;
  logic [15:0] relay_controls;
  logic [7:0]  option_controls;
  logic [23:0] a_cb, a_fs, p_cb, p_fs;
  int          err_total, checks;
  int          tmr  = 0;
  int          dcnt = 0;
  logic [7:0]  a_tab [10] = '{8'h01, 8'h02, 8'h22, 8'h42, 8'h03, 8'h83, 8'h0C, 8'h05, 8'h0E, 8'h07};
  logic [9:0]  m_tab [10] = '{10'h001, 10'h002, 10'h004, 10'h008, 10'h010, 10'h020, 10'h040, 10'h002,
                              10'h002, 10'h080};
  dmm_link_if link ();
  dmm_processor_end #(.SETTLE_CYCLES(20), .BALANCE_CYCLES(200)) u_dmm_processor_end (
    .clock(clock), .arst_n(arst_n), .link(link), .start(start), .control_word(control_word),
    .fast_select(fast_select), .busy(busy), .host_state(), .result_valid(result_valid),
    .cb_count(p_cb), .fs_count(p_fs));
  dmm_analog_end u_dmm_analog_end (
    .clock(clock), .arst_n(arst_n), .link(link), .duty_cycle_comparator(duty_cmp),
    .final_slope_comparator(fs_cmp), .mux_switch(mux_switch), .gain_x10(gain_x10),
    .charge_balance_feedback_switch(cb_fb), .final_slope_feedback_switch(fs_fb), .range_select(range_select),
    .four_wire(four_wire), .relay_controls(relay_controls), .option_controls(option_controls),
    .conv_state(), .phase_done(phase_done), .cb_count(a_cb), .fs_count(a_fs));
  dmm_link_checker #(.SETTLE_CYCLES(20), .BALANCE_CYCLES(200)) u_dmm_link_checker (
    .clock(clock), .arst_n(arst_n), .shift_clk(link.shift_clk), .shift_data(link.shift_data),
    .strobe(link.strobe), .input_enable(link.input_enable), .cb_toggle(link.cb_toggle),
    .fs_gate(link.fs_gate), .fs_comp(link.fs_comp));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Converter stand-in: duty pulse every 10 cycles, slope lasts 130 cycles after enable drops
  always @(negedge clock) begin
    dcnt <= (dcnt == 4) ? 0 : dcnt + 1;
    if (dcnt == 4) duty_cmp <= ~duty_cmp;
    tmr <= link.input_enable ? 130 : (tmr > 0 ? tmr - 1 : 0);
  end
  assign fs_cmp = (tmr != 0);
  task automatic check_val(input logic [39:0] got, input logic [39:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  task automatic bounded(input logic [1:0] sel);
    int n;
    n = 0;
    while ((sel == 2'h0 ? link.strobe : sel == 2'h1 ? result_valid : sel == 2'h2 ? link.fs_comp : phase_done) !== 1'b1) begin
      @(negedge clock);
      n++;
      if (n > 4000) begin
        check_val(40'h0, 40'h1, "timeout");
        final_report();
      end
    end
  endtask : bounded
  task automatic run(input logic [39:0] word, input logic fast, input logic [9:0] exp_mux);
    control_word = word;
    fast_select  = fast;
    start        = 1'b1;
    @(negedge clock);
    start = 1'b0;
    bounded(2'h0);
    repeat (16) @(negedge clock);
    if (exp_mux[1]) check_val(mux_switch, 10'h100, "precharge");
    bounded(2'h2);
    check_val({cb_fb, fs_fb, busy}, 3'h3, "slope feedback");
    bounded(2'h3);
    bounded(2'h1);
    check_val(p_cb, a_cb, "balance count");
    check_val(p_fs, a_fs, "slope count");
    check_val(a_cb >= 19 && a_cb <= 21 && a_fs > 0, 1, "count size");
    check_val(mux_switch, exp_mux, "mux");
    check_val(gain_x10, word[3], "gain");
  endtask : run
  initial begin
    arst_n       = 1'b0;
    start        = 1'b0;
    fast_select  = 1'b0;
    control_word = '0;
    err_total    = 0;
    checks       = 0;
    repeat (16) @(negedge clock);
    arst_n = 1'b1;
    check_val(mux_switch, 10'h000, "reset mux");
    for (int i = 0; i < 10; i++) begin
      run({32'h96A5_3C43, a_tab[i]}, 1'b0, m_tab[i]);
      check_val({four_wire, range_select, relay_controls, option_controls}, {1'b1, 3'h3, 16'hA53C, 8'h96},
                "chain");
      $display("phase test %0d done", i);
    end
    run({32'h96A5_3C2B, 8'h06}, 1'b0, 10'h002);
    check_val({four_wire, range_select}, 4'h8, "rtd range");
    $display("rtd test done");
    // The fast bit must already be held before a short load is taken
    run({32'h96A5_3C33, 8'h11}, 1'b0, 10'h001);
    check_val(range_select, 3'h0, "thermocouple range");
    $display("thermocouple test done");
    // Fast load carries new middle registers that must be ignored
    run({8'h69, 24'h00_0000, 8'h11}, 1'b1, 10'h001);
    check_val(relay_controls, 16'hA53C, "held relays");
    check_val(option_controls, 8'h69, "option");
    $display("fast test done");
    final_report();
  end
endmodule : testbench
